// ==== core/cam_regs.svh ====
// register map, field positions, reset values and timing counts of the alarm monitor
// How it works
// RULE1: four alarm channels, each with its own full set of settings.
// RULE2: enable on evaluates the source; off (reset default) does no monitoring.
// RULE3: each channel picks one of sixteen logic flags, index one to sixteen.
// RULE4: alarm rises after the source is true for the delay, 0.3-999.9 s, default 5.0 s.
// RULE5: a false source before the delay ends restarts the timer from zero.
// RULE6: class A-F or Control, default B, reported together with the alarm.
// RULE7: self-acknowledge yes clears the alarm once the fault is gone.
// RULE8: self-acknowledge no (default) keeps the alarm until an outside clear.
// RULE9: lock yes suspends detection while the global inhibit status is true.
// RULE10: lock no (default) monitors continuously, ignoring the inhibit status.
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

// byte offsets, one aligned word each
`define CAM_CFG_BASE 8'h00
`define CAM_DLY_BASE 8'h10
`define CAM_ALARM_OFS 8'h20
`define CAM_IST_OFS 8'h24
`define CAM_IMASK_OFS 8'h28
`define CAM_ACK_OFS 8'h2c

// channel configuration word fields
`define CAM_CFG_EN_BIT 0
`define CAM_CFG_SRC_LSB 4
`define CAM_CFG_CLS_LSB 8
`define CAM_CFG_SACK_BIT 12
`define CAM_CFG_LOCK_BIT 13

// reset values and limits, delay in 0.1 s steps
`define CAM_CLS_RST 3'h1
`define CAM_DLY_RST 14'h0032
`define CAM_DLY_MIN 14'h0003
`define CAM_DLY_MAX 14'h270f

// time base: one delay step is 0.1 s
`define CAM_STEP_NS 100000000
`define CAM_CLK_NS 4
`define CAM_STEP_CYCLES (`CAM_STEP_NS / `CAM_CLK_NS)

`endif

// ==== core/cam_pkg.sv ====
// types shared by the alarm monitor
package cam_pkg;
    // alarm class encoding
    typedef enum logic [2:0] {
        CAM_CLS_A,
        CAM_CLS_B,
        CAM_CLS_C,
        CAM_CLS_D,
        CAM_CLS_E,
        CAM_CLS_F,
        CAM_CLS_CONTROL
    } cam_class_type;

    // per-channel settings
    typedef struct packed {
        logic en;
        logic [3:0] src;
        cam_class_type cls;
        logic self_ack;
        logic lock;
        logic [13:0] delay;
    } cam_chan_cfg_type;
endpackage

// ==== core/cam_top.sv ====
// four-channel configurable alarm monitor with apb register access
`include "cam_regs.svh"

module cam_top #(
    parameter int unsigned NUM_CHAN = 4,
    parameter int unsigned STEP_CYCLES = `CAM_STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // monitored flags and global inputs
    input wire logic [15:0] logic_flag_source_i,
    input wire logic monitor_inhibit_i,
    input wire logic ext_ack_i,
    // alarm outputs
    output logic [3:0] alarm_o,
    output logic [11:0] alarm_class_o,
    output logic irq_o
);

    initial
    begin
        if (NUM_CHAN != 4)
            $error("cam_top: exactly four channels are supported");
        if (STEP_CYCLES < 1)
            $error("cam_top: STEP_CYCLES must be at least one");
    end

    // whole module state
    typedef struct packed {
        cam_pkg::cam_chan_cfg_type [3:0] cfg;
        logic [3:0][31:0] sub;
        logic [3:0][13:0] steps;
        logic [3:0] alarm;
        logic [3:0] ist;
        logic [3:0] imask;
        logic [31:0] prdata;
        logic slverr;
    } cam_state_type;

    cam_state_type st_r;
    cam_state_type st_nxt;

    // pack a channel's settings into its configuration word
    function automatic logic [31:0] cfg_word(input cam_pkg::cam_chan_cfg_type c);
        logic [31:0] w;
        w = 32'h0;
        w[`CAM_CFG_EN_BIT] = c.en;
        w[`CAM_CFG_SRC_LSB +: 4] = c.src;
        w[`CAM_CFG_CLS_LSB +: 3] = c.cls;
        w[`CAM_CFG_SACK_BIT] = c.self_ack;
        w[`CAM_CFG_LOCK_BIT] = c.lock;
        return w;
    endfunction

    // keep a written delay inside the legal 0.3 .. 999.9 s range
    function automatic logic [13:0] clamp_delay(input logic [31:0] d);
        logic [13:0] r;
        if (d < 32'(`CAM_DLY_MIN))
            r = `CAM_DLY_MIN;
        else if (d > 32'(`CAM_DLY_MAX))
            r = `CAM_DLY_MAX;
        else
            r = d[13:0];
        return r;
    endfunction

    // an unused class code falls back to control rather than to an undefined class
    function automatic cam_pkg::cam_class_type fix_class(input logic [2:0] c);
        cam_pkg::cam_class_type r;
        if (c > 3'(cam_pkg::CAM_CLS_CONTROL))
            r = cam_pkg::CAM_CLS_CONTROL;
        else
            r = cam_pkg::cam_class_type'(c);
        return r;
    endfunction

    logic wr_acc;
    logic rd_setup;
    logic [3:0] clr_req;
    logic [3:0] alarm_set;
    logic [3:0] evaluate;
    logic [3:0] fault;

    // zero wait states: a write lands at the access edge, read data is fetched in setup
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i;

    always_comb
    begin
        st_nxt = st_r;
        clr_req = 4'h0;
        alarm_set = 4'h0;
        evaluate = 4'h0;
        fault = 4'h0;

        // register writes
        if (wr_acc)
        begin
            if (paddr_i[7:4] == 4'h0)
            begin
                st_nxt.cfg[paddr_i[3:2]].en = pwdata_i[`CAM_CFG_EN_BIT]; // RULE1
                st_nxt.cfg[paddr_i[3:2]].src = pwdata_i[`CAM_CFG_SRC_LSB +: 4]; // RULE3
                st_nxt.cfg[paddr_i[3:2]].cls = fix_class(pwdata_i[`CAM_CFG_CLS_LSB +: 3]);
                st_nxt.cfg[paddr_i[3:2]].self_ack = pwdata_i[`CAM_CFG_SACK_BIT];
                st_nxt.cfg[paddr_i[3:2]].lock = pwdata_i[`CAM_CFG_LOCK_BIT];
            end
            else if (paddr_i[7:4] == 4'h1)
            begin
                st_nxt.cfg[paddr_i[3:2]].delay = clamp_delay(pwdata_i); // RULE4
            end
            else if (paddr_i == `CAM_IMASK_OFS)
            begin
                st_nxt.imask = pwdata_i[3:0];
            end
            else if (paddr_i == `CAM_ACK_OFS)
            begin
                clr_req = pwdata_i[3:0]; // RULE8
            end
        end

        // the discrete acknowledge clears every latched alarm except one whose fault is still held past its delay
        if (ext_ack_i)
            clr_req = 4'hf; // RULE8

        // per-channel detection
        for (int i = 0; i < 4; i++)
        begin
            evaluate[i] = st_r.cfg[i].en && !(st_r.cfg[i].lock && monitor_inhibit_i); // RULE9 RULE10
            fault[i] = logic_flag_source_i[st_r.cfg[i].src]; // RULE3
            if (!st_r.cfg[i].en)
            begin
                // disabled: no timing and no alarm at all
                st_nxt.sub[i] = 32'h0; // RULE2
                st_nxt.steps[i] = 14'h0;
                st_nxt.alarm[i] = 1'b0; // RULE2
            end
            else if (!evaluate[i])
            begin
                // locked out: detection suspended, a latched alarm is kept until an acknowledge clears it
                st_nxt.sub[i] = 32'h0; // RULE9
                st_nxt.steps[i] = 14'h0;
                st_nxt.alarm[i] = st_r.alarm[i] & ~clr_req[i];
            end
            else if (!fault[i])
            begin
                // any interruption restarts the delay from zero
                st_nxt.sub[i] = 32'h0; // RULE5
                st_nxt.steps[i] = 14'h0; // RULE5
                if (st_r.cfg[i].self_ack)
                    st_nxt.alarm[i] = 1'b0; // RULE7
                else
                    st_nxt.alarm[i] = st_r.alarm[i] & ~clr_req[i]; // RULE8
            end
            else if (st_r.steps[i] >= st_r.cfg[i].delay)
            begin
                // delay elapsed: a set always beats a clear in the same cycle
                alarm_set[i] = 1'b1; // RULE4
                st_nxt.alarm[i] = 1'b1;
            end
            else
            begin
                // each channel has its own prescaler so the delay starts exactly at the edge
                if (st_r.sub[i] >= 32'(STEP_CYCLES - 1))
                begin
                    st_nxt.sub[i] = 32'h0;
                    st_nxt.steps[i] = st_r.steps[i] + 14'h1; // RULE4
                end
                else
                begin
                    st_nxt.sub[i] = st_r.sub[i] + 32'h1;
                end
                st_nxt.alarm[i] = st_r.alarm[i] & ~clr_req[i];
            end
        end

        // sticky interrupt status: rising alarms set, write one clears, set wins
        st_nxt.ist = st_r.ist;
        if (wr_acc && paddr_i == `CAM_IST_OFS)
            st_nxt.ist = st_r.ist & ~pwdata_i[3:0];
        st_nxt.ist = st_nxt.ist | (st_nxt.alarm & ~st_r.alarm);

        // read data and error answer, prepared in the setup cycle
        if (rd_setup)
        begin
            st_nxt.prdata = 32'h0;
            st_nxt.slverr = 1'b0;
            if (paddr_i[7:4] == 4'h0 && paddr_i[1:0] == 2'h0)
                st_nxt.prdata = cfg_word(st_r.cfg[paddr_i[3:2]]);
            else if (paddr_i[7:4] == 4'h1 && paddr_i[1:0] == 2'h0)
                st_nxt.prdata = {18'h0, st_r.cfg[paddr_i[3:2]].delay};
            else if (paddr_i == `CAM_ALARM_OFS)
                st_nxt.prdata = {28'h0, st_r.alarm};
            else if (paddr_i == `CAM_IST_OFS)
                st_nxt.prdata = {28'h0, st_r.ist};
            else if (paddr_i == `CAM_IMASK_OFS)
                st_nxt.prdata = {28'h0, st_r.imask};
            else if (paddr_i == `CAM_ACK_OFS)
                st_nxt.prdata = 32'h0;
            else
                st_nxt.slverr = 1'b1;
        end
    end

    // state register, reset to the documented defaults
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                st_r.cfg[i].en <= 1'b0; // RULE2
                st_r.cfg[i].src <= 4'h0;
                st_r.cfg[i].cls <= cam_pkg::cam_class_type'(`CAM_CLS_RST); // RULE6
                st_r.cfg[i].self_ack <= 1'b0; // RULE8
                st_r.cfg[i].lock <= 1'b0; // RULE10
                st_r.cfg[i].delay <= `CAM_DLY_RST; // RULE4
                st_r.sub[i] <= 32'h0;
                st_r.steps[i] <= 14'h0;
            end
            st_r.alarm <= 4'h0;
            st_r.ist <= 4'h0;
            st_r.imask <= 4'h0;
            st_r.prdata <= 32'h0;
            st_r.slverr <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs; the class travels next to each alarm bit
    assign prdata_o = st_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & st_r.slverr;
    assign alarm_o = st_r.alarm;
    assign irq_o = |(st_r.ist & st_r.imask);

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cls
            assign alarm_class_o[g*3 +: 3] = st_r.cfg[g].cls; // RULE6
        end
    endgenerate

    // assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence fault_held(int k);
        evaluate[k] && fault[k];
    endsequence

    disabled_quiet_a: assert property (!st_r.cfg[0].en |=> !alarm_o[0]) // RULE2
        else $error("disabled channel raised an alarm");
    no_early_a: assert property ($rose(alarm_o[0]) |-> $past(st_r.steps[0]) >= st_r.cfg[0].delay) // RULE4
        else $error("alarm rose before the delay elapsed");
    restart_a: assert property (st_r.cfg[0].en && !fault[0] |=> st_r.steps[0] == 14'h0) // RULE5
        else $error("delay timer not restarted");
    delay_range_a: assert property (st_r.cfg[0].delay >= `CAM_DLY_MIN && st_r.cfg[0].delay <= `CAM_DLY_MAX) // RULE4
        else $error("delay outside legal range");
    self_clear_a: assert property (fault_held(0) ##1 (evaluate[0] && !fault[0] && st_r.cfg[0].self_ack)
        |=> !alarm_o[0]) // RULE7
        else $error("self acknowledge did not clear alarm");
    latched_a: assert property (alarm_o[0] && !st_r.cfg[0].self_ack && st_r.cfg[0].en && !clr_req[0]
        |=> alarm_o[0]) // RULE8
        else $error("latched alarm dropped without a clear");
    lock_hold_a: assert property (st_r.cfg[0].en && st_r.cfg[0].lock && monitor_inhibit_i
        |=> st_r.steps[0] == 14'h0 && !$rose(alarm_o[0])) // RULE9
        else $error("locked channel kept timing under inhibit");
    unlock_run_a: assert property (st_r.cfg[0].en && !st_r.cfg[0].lock && fault[0]
        |-> evaluate[0]) // RULE10
        else $error("unlocked channel stopped by inhibit");
    irq_level_a: assert property ($rose(alarm_o[0]) |-> st_r.ist[0] && (irq_o || !st_r.imask[0]))
        else $error("rising alarm did not set status");
endmodule

// ==== bench/cam_tb.sv ====
// self-checking bench of the four-channel alarm monitor
`include "cam_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // short time step keeps the delay counts small
    localparam int unsigned STEP = 2;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [15:0] logic_flag_source_i = 16'h0;
    logic monitor_inhibit_i = 1'b0;
    logic ext_ack_i = 1'b0;
    logic [3:0] alarm_o;
    logic [11:0] alarm_class_o;
    logic irq_o;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0;
    int n_tests = 0;

    cam_top #(.NUM_CHAN(4), .STEP_CYCLES(STEP)) dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .logic_flag_source_i(logic_flag_source_i), .monitor_inhibit_i(monitor_inhibit_i),
        .ext_ack_i(ext_ack_i), .alarm_o(alarm_o), .alarm_class_o(alarm_class_o), .irq_o(irq_o));

    // 250 MHz clock
    always #2 sys_clk_i = ~sys_clk_i;

    task automatic stop_test();
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask

    // settle one ns past the edge so the edge's updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic setf(input logic [15:0] f);
        @(posedge sys_clk_i);
        logic_flag_source_i <= f;
    endtask

    task automatic al(input logic [3:0] exp);
        chk("alarm", {28'h0, alarm_o}, {28'h0, exp});
    endtask

    function automatic logic [31:0] cfgw(input logic en, input logic [3:0] src,
        input logic [2:0] cls, input logic sack, input logic lock);
        cfgw = {18'h0, lock, sack, 1'b0, cls, src, 3'h0, en};
    endfunction

    task automatic t_reset();
        rd(`CAM_CFG_BASE, 32'h100, "cfg0");
        rd(`CAM_DLY_BASE, 32'h32, "dly0");
        chk("class", {20'h0, alarm_class_o}, 32'h249);
        for (int i = 0; i < 4; i++)
            apb(1'b1, `CAM_DLY_BASE + 8'(4 * i), 32'h3);
        setf(16'hffff);
        cyc(20);
        al(4'h0);
        setf(16'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk("err", {31'h0, rerr}, 32'h1);
    endtask

    // wrong flag ignored, then a broken true period restarts the timer
    task automatic t_delay();
        apb(1'b1, `CAM_CFG_BASE, cfgw(1'b1, 4'h3, 3'h1, 1'b0, 1'b0));
        setf(16'h0004);
        cyc(20);
        al(4'h0);
        setf(16'h0008);
        cyc(4);
        setf(16'h0);
        setf(16'h0008);
        cyc(5);
        al(4'h0);
        cyc(1);
        al(4'h0);
        cyc(1);
        al(4'h1);
    endtask

    task automatic t_irq();
        chk("irq", {31'h0, irq_o}, 32'h0);
        rd(`CAM_IST_OFS, 32'h1, "ist");
        apb(1'b1, `CAM_IMASK_OFS, 32'h1);
        cyc(1);
        chk("irq", {31'h0, irq_o}, 32'h1);
        apb(1'b1, `CAM_IST_OFS, 32'h1);
        cyc(1);
        chk("irq", {31'h0, irq_o}, 32'h0);
    endtask

    task automatic t_ack();
        setf(16'h0);
        cyc(5);
        al(4'h1);
        apb(1'b1, `CAM_ACK_OFS, 32'h1);
        cyc(2);
        al(4'h0);
        setf(16'h0008);
        cyc(10);
        al(4'h1);
        setf(16'h0);
        @(posedge sys_clk_i);
        ext_ack_i <= 1'b1;
        @(posedge sys_clk_i);
        ext_ack_i <= 1'b0;
        cyc(2);
        al(4'h0);
    endtask

    task automatic t_self();
        apb(1'b1, `CAM_CFG_BASE, cfgw(1'b1, 4'h3, 3'h1, 1'b1, 1'b1));
        setf(16'h0008);
        cyc(10);
        al(4'h1);
        setf(16'h0);
        cyc(2);
        al(4'h0);
        @(posedge sys_clk_i);
        monitor_inhibit_i <= 1'b1;
        setf(16'h0008);
        cyc(20);
        al(4'h0);
        apb(1'b1, `CAM_CFG_BASE, cfgw(1'b1, 4'h3, 3'h1, 1'b1, 1'b0));
        cyc(10);
        al(4'h1);
        @(posedge sys_clk_i);
        monitor_inhibit_i <= 1'b0;
        apb(1'b1, `CAM_CFG_BASE, 32'h0);
        cyc(2);
        al(4'h0);
    endtask

    // every class code on channel 3 (unused code 7 reads as control), then channel 3 alone alarms
    task automatic t_chan();
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, `CAM_CFG_BASE + 8'hc, cfgw(1'b0, 4'hf, 3'(c), 1'b0, 1'b0));
            cyc(1);
            chk("cls3", {29'h0, alarm_class_o[11:9]}, (c == 7) ? 32'h6 : 32'(c));
            // channel 0 was written all zero earlier, so its class is A
            chk("cls012", {23'h0, alarm_class_o[8:0]}, 32'h48);
        end
        apb(1'b1, `CAM_CFG_BASE + 8'hc, cfgw(1'b1, 4'hf, 3'h4, 1'b0, 1'b0));
        setf(16'h8008);
        cyc(10);
        al(4'h8);
        rd(`CAM_ALARM_OFS, 32'h8, "alarm_reg");
    endtask

    // hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        #100000;
        errors++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_delay();
        t_irq();
        t_ack();
        t_self();
        t_chan();
        stop_test();
    end
endmodule
